// ===== core/timer_wdt_map.svh
`ifndef TIMER_WDT_MAP_SVH
`define TIMER_WDT_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define OFS_CORE_CONTROL   6'h00
`define OFS_TIMER_COUNTER  6'h04
`define OFS_PORT5_DIR      6'h08
`define OFS_PORT6_DIR      6'h0c
`define OFS_PULLDOWN       6'h10
`define OFS_OPEN_DRAIN     6'h14
`define OFS_PULLUP         6'h18
`define OFS_WDT_CONTROL    6'h1c
`define OFS_IRQ_MASK       6'h20
`define OFS_IRQ_FLAGS      6'h24
`define OFS_COMMAND        6'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define CC_GLOBAL_IRQ      6
`define CC_SOURCE          5
`define CC_EDGE            4
`define CC_OWNER           3
`define WC_ENABLE          7
`define WC_EXT_SELECT      6
`define IRQ_EXT            2
`define IRQ_CHANGE         1
`define IRQ_TIMER          0
`define CMD_IRQ_ON         0
`define CMD_IRQ_OFF        1
`define CMD_RETURN_IRQ     2
`define CMD_WDT_CLEAR      3
`define CMD_SLEEP          4
`define CMD_IRQ_ENTRY      5
`define UNUSED_BIT         3

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CORE_CONTROL   8'hbf
`define RST_PORT5_DIR      4'hf
`define RST_PORT6_DIR      8'hff
`define RST_PULLDOWN       8'hff
`define RST_OPEN_DRAIN     8'h00
`define RST_PULLUP         8'hff
`define RST_WDT_CONTROL    8'h80
`define MASK_UPPER_ONES    8'hf8

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS      10
`define WDT_PERIOD_MS      18

`endif

// ===== core/timer_wdt_pkg.sv
package timer_wdt_pkg;

	typedef struct packed {
		logic [3:0] port5_dir;
		logic [7:0] port6_dir;
		logic [7:0] pulldown_off;
		logic [7:0] open_drain;
		logic [7:0] pullup_off;
		logic       ext_irq_pin_select;
		logic       count_pin_is_input;
	} pin_cfg_t;

	typedef struct packed {
		logic        waitreq;
		logic [7:0]  rdata;
		logic [7:0]  core_control;
		logic [7:0]  timer;
		pin_cfg_t    pins;
		logic [7:0]  wdt_control;
		logic [2:0]  irq_mask;
		logic [2:0]  flags;
		logic [7:0]  presc;
		logic [23:0] wdt_cnt;
		logic [1:0]  cyc_div;
		logic [1:0]  cnt_sync;
		logic        cnt_prev;
		logic [1:0]  ext_sync;
		logic        ext_prev;
		logic [1:0]  chg_sync;
		logic        chg_prev;
		logic [1:0]  div_sync;
		logic        irq_req;
		logic        wdt_reset;
	} state_t;

endpackage : timer_wdt_pkg

// ===== core/timer_wdt_ctrl.sv
// Operation
// [R1] Control bit 6 shows global interrupt enable.
// [R2] Bit 5 picks cycle clock or pin.
// [R3] Bit 4 picks rising or falling pin edge.
// [R4] Bit 3 gives prescaler to timer or watchdog.
// [R5] Bits 2..0 pick the divide ratio.
// [R6] Direction bit 0 drives, 1 floats pin.
// [R7] Port5 direction upper nibble reads zero.
// [R8] Pull-down bits active low, bit 3 one.
// [R9] Open-drain bits active high, bit 3 zero.
// [R10] Pull-high bits active low, bit 3 one.
// [R11] Watchdog bit 7 enables, 5..0 storage.
// [R12] Watchdog bit 6 routes external interrupt pin.
// [R13] Mask bits 2..0 enable, 7..3 read one.
// [R14] Interrupt needs mask bit and global enable.
// [R15] One prescaler, one owner at a time.
// [R16] Timer write clears timer-owned prescaler.
// [R17] Watchdog clear or sleep clears watchdog.
// [R18] Eight-bit timer, one step per cycle.
// [R19] Cycle clock is main clock over 2/4.
// [R20] Watchdog time-out resets device when enabled.
// [R21] Unprescaled watchdog period about 18 ms.
// [R22] Software may toggle watchdog enable anytime.
// [R23] Timer wraps and sets overflow flag.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "timer_wdt_map.svh"

module timer_wdt_ctrl
	import timer_wdt_pkg::*;
#(
	parameter int WDT_TIMEOUT_CYCLES = `WDT_PERIOD_MS * 1000000 / `CLK_PERIOD_NS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        count_input_pin,
	input  wire logic        shared_irq_io_pin,
	input  wire logic        port_change_level,
	input  wire logic        cycle_div4_option,
	output pin_cfg_t         pin_cfg,
	output logic             irq_request,
	output logic             watchdog_reset
);

	// ****************************************************************
	// State and helpers
	// ****************************************************************
	localparam logic [23:0] WDT_LAST = 24'(WDT_TIMEOUT_CYCLES - 1);

	state_t st_r;
	state_t st_nxt;

	logic       req;
	logic       wr_take;
	logic [7:0] wdat;
	logic       cmd_wr;
	logic       owner_wdt;
	logic       cyc_tick;
	logic       pin_edge;
	logic       src_evt;
	logic       presc_evt;
	logic [3:0] presc_n;
	logic       presc_tick;
	logic       timer_inc;
	logic       wdt_inc;
	logic       timer_wr;
	logic       wdt_clr;
	logic [2:0] flag_set;
	logic       glob_set;
	logic       glob_clr;

	// The ratio is a power of two, so a tick is the low n bits all set.
	function automatic logic presc_hit(input logic [7:0] p, input logic [3:0] n);
		logic [7:0] mask;
		mask = 8'((16'h0001 << n) - 16'h0001);
		return (p & mask) == mask;
	endfunction : presc_hit

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;

		req     = avs_read | avs_write;
		wr_take = avs_write & ~st_r.waitreq & avs_byteenable[0];
		wdat    = avs_writedata[7:0];
		cmd_wr  = wr_take && (avs_address == `OFS_COMMAND);

		// Synchronisers; the second stage alone feeds logic.
		st_nxt.cnt_sync = {st_r.cnt_sync[0], count_input_pin};
		st_nxt.ext_sync = {st_r.ext_sync[0], shared_irq_io_pin};
		st_nxt.chg_sync = {st_r.chg_sync[0], port_change_level};
		st_nxt.div_sync = {st_r.div_sync[0], cycle_div4_option};
		st_nxt.cnt_prev = st_r.cnt_sync[1];
		st_nxt.ext_prev = st_r.ext_sync[1];
		st_nxt.chg_prev = st_r.chg_sync[1];

		// Instruction cycle tick, one in two or one in four clocks.
		cyc_tick = st_r.cyc_div == (st_r.div_sync[1] ? 2'd3 : 2'd1); // [R19]
		st_nxt.cyc_div = cyc_tick ? 2'd0 : st_r.cyc_div + 2'd1;

		pin_edge = st_r.core_control[`CC_EDGE] ? (st_r.cnt_prev & ~st_r.cnt_sync[1])
		                                       : (~st_r.cnt_prev & st_r.cnt_sync[1]); // [R3]
		src_evt  = st_r.core_control[`CC_SOURCE] ? pin_edge : cyc_tick; // [R2] [R18]

		// Watchdog base time steps every clock; the prescaler has one owner.
		owner_wdt  = st_r.core_control[`CC_OWNER]; // [R4] [R15]
		presc_evt  = owner_wdt ? 1'b1 : src_evt;
		presc_n    = owner_wdt ? {1'b0, st_r.core_control[2:0]}
		                       : {1'b0, st_r.core_control[2:0]} + 4'd1; // [R5]
		presc_tick = presc_evt & presc_hit(st_r.presc, presc_n);
		timer_inc  = owner_wdt ? src_evt : presc_tick;
		wdt_inc    = owner_wdt ? presc_tick : 1'b1;

		timer_wr = wr_take && (avs_address == `OFS_TIMER_COUNTER);
		wdt_clr  = cmd_wr && (wdat[`CMD_WDT_CLEAR] || wdat[`CMD_SLEEP]);

		// Prescaler.
		if ((timer_wr && !owner_wdt) || (wdt_clr && owner_wdt)) begin
			st_nxt.presc = 8'h00; // [R16] [R17]
		end else if (presc_evt) begin
			st_nxt.presc = st_r.presc + 8'h01;
		end

		// Timer counter; a write wins over a count in the same cycle.
		flag_set = 3'b000;
		if (timer_wr) begin
			st_nxt.timer = wdat;
		end else if (timer_inc) begin
			st_nxt.timer = st_r.timer + 8'h01; // [R18] [R23]
			flag_set[`IRQ_TIMER] = (st_r.timer == 8'hff); // [R23]
		end

		// Watchdog counter.
		st_nxt.wdt_reset = 1'b0;
		if (wdt_clr || !st_r.wdt_control[`WC_ENABLE]) begin
			st_nxt.wdt_cnt = 24'h00_0000; // [R17] [R11]
		end else if (wdt_inc) begin
			if (st_r.wdt_cnt == WDT_LAST) begin
				st_nxt.wdt_cnt   = 24'h00_0000;
				st_nxt.wdt_reset = 1'b1; // [R20] [R21]
			end else begin
				st_nxt.wdt_cnt = st_r.wdt_cnt + 24'h00_0001; // [R21]
			end
		end

		// Interrupt sources; the external one is an active-low pin.
		flag_set[`IRQ_EXT] = st_r.pins.ext_irq_pin_select
		                     & st_r.ext_prev & ~st_r.ext_sync[1]; // [R12]
		flag_set[`IRQ_CHANGE] = st_r.chg_prev ^ st_r.chg_sync[1];

		// Write one clears a flag, but a new event in the same cycle survives.
		if (wr_take && (avs_address == `OFS_IRQ_FLAGS)) begin
			st_nxt.flags = (st_r.flags & ~wdat[2:0]) | flag_set;
		end else begin
			st_nxt.flags = st_r.flags | flag_set;
		end

		// Global enable; set wins when both arrive together.
		glob_set = cmd_wr && (wdat[`CMD_IRQ_ON] || wdat[`CMD_RETURN_IRQ]);
		glob_clr = cmd_wr && (wdat[`CMD_IRQ_OFF] || wdat[`CMD_IRQ_ENTRY]);

		// Register writes.
		if (wr_take) begin
			unique case (avs_address)
				`OFS_CORE_CONTROL: begin
					st_nxt.core_control = wdat;
				end
				`OFS_PORT5_DIR: begin
					st_nxt.pins.port5_dir = wdat[3:0]; // [R6] [R7]
				end
				`OFS_PORT6_DIR: begin
					st_nxt.pins.port6_dir = wdat; // [R6]
				end
				`OFS_PULLDOWN: begin
					st_nxt.pins.pulldown_off = wdat | 8'h08; // [R8]
				end
				`OFS_OPEN_DRAIN: begin
					st_nxt.pins.open_drain = wdat & 8'hf7; // [R9]
				end
				`OFS_PULLUP: begin
					st_nxt.pins.pullup_off = wdat | 8'h08; // [R10]
				end
				`OFS_WDT_CONTROL: begin
					st_nxt.wdt_control = wdat; // [R11] [R22]
				end
				`OFS_IRQ_MASK: begin
					st_nxt.irq_mask = wdat[2:0]; // [R13]
				end
				default: begin
				end
			endcase
		end

		if (glob_set) begin
			st_nxt.core_control[`CC_GLOBAL_IRQ] = 1'b1; // [R1]
		end else if (glob_clr) begin
			st_nxt.core_control[`CC_GLOBAL_IRQ] = 1'b0; // [R1]
		end

		st_nxt.pins.ext_irq_pin_select = st_nxt.wdt_control[`WC_EXT_SELECT]; // [R12]
		st_nxt.pins.count_pin_is_input = st_nxt.core_control[`CC_SOURCE]; // [R2]

		st_nxt.irq_req = st_r.core_control[`CC_GLOBAL_IRQ]
		                 & |(st_r.irq_mask & st_r.flags); // [R14]

		// One wait cycle, then the answer for one cycle.
		st_nxt.waitreq = ~(req & st_r.waitreq);
		if (req && st_r.waitreq) begin
			unique case (avs_address)
				`OFS_CORE_CONTROL:  st_nxt.rdata = st_r.core_control;
				`OFS_TIMER_COUNTER: st_nxt.rdata = st_r.timer;
				`OFS_PORT5_DIR:     st_nxt.rdata = {4'h0, st_r.pins.port5_dir}; // [R7]
				`OFS_PORT6_DIR:     st_nxt.rdata = st_r.pins.port6_dir;
				`OFS_PULLDOWN:      st_nxt.rdata = st_r.pins.pulldown_off;
				`OFS_OPEN_DRAIN:    st_nxt.rdata = st_r.pins.open_drain;
				`OFS_PULLUP:        st_nxt.rdata = st_r.pins.pullup_off;
				`OFS_WDT_CONTROL:   st_nxt.rdata = st_r.wdt_control;
				`OFS_IRQ_MASK:      st_nxt.rdata = `MASK_UPPER_ONES | {5'h00, st_r.irq_mask};
				`OFS_IRQ_FLAGS:     st_nxt.rdata = {5'h00, st_r.flags};
				default:            st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r                   <= '0;
			st_r.waitreq           <= 1'b1;
			st_r.core_control      <= `RST_CORE_CONTROL;
			st_r.pins.port5_dir    <= `RST_PORT5_DIR;
			st_r.pins.port6_dir    <= `RST_PORT6_DIR;
			st_r.pins.pulldown_off <= `RST_PULLDOWN;
			st_r.pins.open_drain   <= `RST_OPEN_DRAIN;
			st_r.pins.pullup_off   <= `RST_PULLUP;
			st_r.pins.count_pin_is_input <= 1'b1;
			st_r.wdt_control       <= `RST_WDT_CONTROL;
			// The count pin idles low, so a high reset value would count a false edge.
			st_r.cnt_prev          <= 1'b0;
			st_r.ext_prev          <= 1'b1;
			st_r.cnt_sync          <= 2'b00;
			st_r.ext_sync          <= 2'b11;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata    = {24'h00_0000, st_r.rdata};
	assign avs_waitrequest = st_r.waitreq;
	assign pin_cfg         = st_r.pins;
	assign irq_request     = st_r.irq_req;
	assign watchdog_reset  = st_r.wdt_reset;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_cmd(int b);
		wr_take && avs_address == `OFS_COMMAND && wdat[b];
	endsequence

	property p_glob_on;
		s_cmd(`CMD_IRQ_ON) |=> st_r.core_control[`CC_GLOBAL_IRQ];
	endproperty
	a_glob_on: assert property (p_glob_on) else $error("global enable not set"); // [R1]

	property p_glob_off;
		s_cmd(`CMD_IRQ_OFF) ##0 !glob_set |=> !st_r.core_control[`CC_GLOBAL_IRQ];
	endproperty
	a_glob_off: assert property (p_glob_off) else $error("global enable not cleared"); // [R1]

	property p_p5_upper;
		!avs_waitrequest && avs_read && avs_address == `OFS_PORT5_DIR
			|-> avs_readdata[7:4] == 4'h0;
	endproperty
	a_p5_upper: assert property (p_p5_upper) else $error("port5 upper bits not zero"); // [R7]

	property p_unused_bits;
		pin_cfg.pulldown_off[3] && pin_cfg.pullup_off[3] && !pin_cfg.open_drain[3];
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unused bit 3 wrong"); // [R8]

	property p_mask_upper;
		!avs_waitrequest && avs_read && avs_address == `OFS_IRQ_MASK
			|-> avs_readdata[7:3] == 5'h1f;
	endproperty
	a_mask_upper: assert property (p_mask_upper) else $error("mask upper bits not one"); // [R13]

	property p_irq_gate;
		irq_request |-> $past(st_r.core_control[`CC_GLOBAL_IRQ])
		                && ($past(st_r.irq_mask) & $past(st_r.flags)) != 3'b000;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enables"); // [R14]

	property p_presc_timer_clr;
		timer_wr && !owner_wdt |=> st_r.presc == 8'h00;
	endproperty
	a_presc_timer_clr: assert property (p_presc_timer_clr) else $error("prescaler kept"); // [R16]

	property p_wdt_clr;
		wdt_clr |=> st_r.wdt_cnt == 24'h00_0000 && (!owner_wdt || st_r.presc == 8'h00);
	endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared"); // [R17]

	property p_overflow;
		timer_inc && !timer_wr && st_r.timer == 8'hff
			|=> st_r.timer == 8'h00 && st_r.flags[`IRQ_TIMER];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // [R23]

	property p_wdt_reset;
		watchdog_reset |-> $past(st_r.wdt_control[`WC_ENABLE]) && st_r.wdt_cnt == 24'h00_0000;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("reset while disabled"); // [R20]

	property p_cycle_div2;
		cyc_tick && st_r.div_sync == 2'b00 && !cycle_div4_option
			|=> !cyc_tick ##1 cyc_tick;
	endproperty
	a_cycle_div2: assert property (p_cycle_div2) else $error("cycle tick not every 2"); // [R19]

endmodule : timer_wdt_ctrl

// ===== dv/pin_driver.sv
`timescale 1ns/1ps

module pin_driver (
	input  wire logic clk,
	input  wire logic cnt_lvl,
	input  wire logic ext_lvl,
	input  wire logic chg_lvl,
	output logic      count_input_pin,
	output logic      shared_irq_io_pin,
	output logic      port_change_level
);
	// Pins move only on clock edges, so every edge the bench asks for is seen once.
	initial begin
		count_input_pin = 1'b0;
		shared_irq_io_pin = 1'b1;
		port_change_level = 1'b0;
	end
	always @(posedge clk) begin
		count_input_pin   <= cnt_lvl;
		shared_irq_io_pin <= ext_lvl;
		port_change_level <= chg_lvl;
	end
endmodule : pin_driver

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "timer_wdt_map.svh"

module tb
	import timer_wdt_pkg::*;
;
	logic        clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        count_input_pin, shared_irq_io_pin, port_change_level;
	logic        cycle_div4_option, irq_request, watchdog_reset;
	logic        cnt_lvl, ext_lvl, chg_lvl;
	pin_cfg_t    pin_cfg, ec;
	logic [7:0]  q, t1, d;
	logic [5:0]  a;
	int          bad_count, checks_done, wdt_pulses, n0, seed;
	logic [5:0]  ra [12] = '{`OFS_CORE_CONTROL, `OFS_TIMER_COUNTER, `OFS_PORT5_DIR,
		`OFS_PORT6_DIR, `OFS_PULLDOWN, `OFS_OPEN_DRAIN, `OFS_PULLUP, `OFS_WDT_CONTROL,
		`OFS_IRQ_MASK, `OFS_IRQ_FLAGS, `OFS_COMMAND, 6'h2c};
	logic [7:0]  rv [12] = '{8'hbf, 8'h00, 8'h0f, 8'hff, 8'hff, 8'h00, 8'hff, 8'h80,
		8'hf8, 8'h00, 8'h00, 8'h00};
	logic [5:0]  ca [8] = '{`OFS_PORT5_DIR, `OFS_PORT6_DIR, `OFS_PULLDOWN, `OFS_OPEN_DRAIN,
		`OFS_PULLUP, `OFS_WDT_CONTROL, `OFS_IRQ_MASK, `OFS_CORE_CONTROL};
	int          cb [4] = '{`CMD_IRQ_ON, `CMD_IRQ_OFF, `CMD_RETURN_IRQ, `CMD_IRQ_ENTRY};

	timer_wdt_ctrl #(.WDT_TIMEOUT_CYCLES(50)) dut (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.count_input_pin(count_input_pin), .shared_irq_io_pin(shared_irq_io_pin),
		.port_change_level(port_change_level), .cycle_div4_option(cycle_div4_option),
		.pin_cfg(pin_cfg), .irq_request(irq_request), .watchdog_reset(watchdog_reset));
	pin_driver partner (.clk(clk), .cnt_lvl(cnt_lvl), .ext_lvl(ext_lvl), .chg_lvl(chg_lvl),
		.count_input_pin(count_input_pin), .shared_irq_io_pin(shared_irq_io_pin),
		.port_change_level(port_change_level));

	// ****************************************************************
	// Bus and compare helpers
	// ****************************************************************
	task bus(input logic w, input logic [3:0] be, input logic [5:0] ad, input logic [7:0] wd,
		output logic [7:0] rd_q);
		int n;
		@(posedge clk);
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, wd};
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			bad_count++;
			finish_test;
		end
		rd_q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task wr(input logic [5:0] ad, input logic [7:0] wd);
		logic [7:0] x;
		bus(1'b1, 4'hf, ad, wd, x);
	endtask : wr
	task rd(input logic [5:0] ad, output logic [7:0] rd_q);
		bus(1'b0, 4'hf, ad, 8'h00, rd_q);
	endtask : rd
	task cmd(input int b);
		wr(`OFS_COMMAND, 8'h01 << b);
	endtask : cmd
	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [7:0] expv(input logic [5:0] ad, input logic [7:0] wd);
		case (ad)
			`OFS_PORT5_DIR: expv = {4'h0, wd[3:0]};
			`OFS_PULLDOWN, `OFS_PULLUP: expv = wd | 8'h08;
			`OFS_OPEN_DRAIN: expv = wd & 8'hf7;
			`OFS_IRQ_MASK: expv = wd | 8'hf8;
			`OFS_CORE_CONTROL: expv = wd & 8'hbf;
			default: expv = wd;
		endcase
	endfunction : expv
	task finish_test;
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (watchdog_reset === 1'b1) wdt_pulses <= wdt_pulses + 1;
	initial begin
		idle(60000);
		bad_count++;
		finish_test;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		{cnt_lvl, chg_lvl, cycle_div4_option, bad_count, checks_done, wdt_pulses} = '0;
		ext_lvl = 1'b1;
		rst = 1'b1;
		seed = 32'he5b3bd46;
		ec = '{4'hf, 8'hff, 8'hff, 8'h00, 8'hff, 1'b0, 1'b1};
		idle(16);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			rd(ra[i], q);
			chk("reset value", rv[i], q);
		end
		chk("reset pins", ec, pin_cfg);
		bus(1'b1, 4'h0, `OFS_PORT6_DIR, 8'h00, q);
		rd(`OFS_PORT6_DIR, q);
		chk("masked write", 8'hff, q);
		for (int i = 0; i < 40; i++) begin
			a = ca[i % 8];
			d = $random(seed);
			wr(a, d);
			rd(a, q);
			chk("readback", expv(a, d), (a == `OFS_CORE_CONTROL) ? q & 8'hbf : q);
			case (a)
				`OFS_PORT5_DIR: ec.port5_dir = d[3:0];
				`OFS_PORT6_DIR: ec.port6_dir = d;
				`OFS_PULLDOWN: ec.pulldown_off = d | 8'h08;
				`OFS_OPEN_DRAIN: ec.open_drain = d & 8'hf7;
				`OFS_PULLUP: ec.pullup_off = d | 8'h08;
				`OFS_WDT_CONTROL: ec.ext_irq_pin_select = d[6];
				`OFS_CORE_CONTROL: ec.count_pin_is_input = d[5];
				default: ;
			endcase
			chk("pin config", ec, pin_cfg);
		end
		for (int i = 0; i < 4; i++) begin
			cmd(cb[i]);
			rd(`OFS_CORE_CONTROL, q);
			chk("global enable", i % 2 == 0, q[6]);
		end
		for (int v = 0; v < 2; v++) begin
			cycle_div4_option <= v[0];
			wr(`OFS_CORE_CONTROL, 8'h08);
			idle(8);
			rd(`OFS_TIMER_COUNTER, t1);
			idle(37);
			rd(`OFS_TIMER_COUNTER, q);
			chk("cycle count", v ? 8'd10 : 8'd20, q - t1);
		end
		cycle_div4_option <= 1'b0;
		for (int p = 0; p < 8; p++) begin
			wr(`OFS_CORE_CONTROL, p);
			rd(`OFS_TIMER_COUNTER, t1);
			idle((3 << (p + 2)) - 3);
			rd(`OFS_TIMER_COUNTER, q);
			chk("prescaled count", 8'd3, q - t1);
		end
		for (int e = 0; e < 2; e++) begin
			wr(`OFS_CORE_CONTROL, e ? 8'h38 : 8'h28);
			wr(`OFS_TIMER_COUNTER, 8'h00);
			cnt_lvl <= 1'b1;
			idle(8);
			rd(`OFS_TIMER_COUNTER, q);
			chk("after rise", 1 - e, q);
			cnt_lvl <= 1'b0;
			idle(8);
			rd(`OFS_TIMER_COUNTER, q);
			chk("after fall", 8'd1, q);
		end
		wr(`OFS_CORE_CONTROL, 8'h08);
		wr(`OFS_IRQ_FLAGS, 8'h07);
		wr(`OFS_IRQ_MASK, 8'h01);
		cmd(`CMD_IRQ_OFF);
		wr(`OFS_TIMER_COUNTER, 8'hfe);
		idle(10);
		rd(`OFS_IRQ_FLAGS, q);
		chk("overflow flag", 1'b1, q[0]);
		chk("irq global off", 1'b0, irq_request);
		cmd(`CMD_IRQ_ON);
		idle(3);
		chk("irq enabled", 1'b1, irq_request);
		wr(`OFS_IRQ_MASK, 8'h00);
		idle(3);
		chk("irq masked", 1'b0, irq_request);
		wr(`OFS_CORE_CONTROL, 8'h68);
		wr(`OFS_IRQ_FLAGS, 8'h07);
		wr(`OFS_WDT_CONTROL, 8'h80);
		ext_lvl <= 1'b0;
		idle(8);
		ext_lvl <= 1'b1;
		idle(8);
		rd(`OFS_IRQ_FLAGS, q);
		chk("ext path off", 8'h00, q);
		wr(`OFS_WDT_CONTROL, 8'hc0);
		ext_lvl <= 1'b0;
		idle(8);
		rd(`OFS_IRQ_FLAGS, q);
		chk("ext flag", 8'h04, q);
		wr(`OFS_IRQ_MASK, 8'h04);
		idle(3);
		chk("ext irq", 1'b1, irq_request);
		chg_lvl <= 1'b1;
		idle(8);
		rd(`OFS_IRQ_FLAGS, q);
		chk("change flag", 8'h06, q);
		for (int p = 0; p < 2; p++) begin
			wr(`OFS_CORE_CONTROL, p ? 8'h29 : 8'h20);
			wr(`OFS_WDT_CONTROL, 8'h80);
			cmd(`CMD_WDT_CLEAR);
			n0 = wdt_pulses;
			idle(p ? 80 : 40);
			chk("no early timeout", n0, wdt_pulses);
			idle(p ? 40 : 20);
			chk("one timeout", n0 + 1, wdt_pulses);
		end
		n0 = wdt_pulses;
		for (int i = 0; i < 8; i++) begin
			cmd(`CMD_SLEEP);
			idle(30);
		end
		chk("sleep clears", n0, wdt_pulses);
		wr(`OFS_WDT_CONTROL, 8'h00);
		idle(150);
		chk("disabled", n0, wdt_pulses);
		finish_test;
	end
endmodule : tb
